// File: hw/rpq_pkg.sv
// package for the remote packet qualifier handler
// assumes a byte-wide receive and transmit character stream from a uart
package rpq_pkg;
  localparam logic [7:0] CH_SOP_RX  = 8'h3c;
  localparam logic [7:0] CH_SOP_TX  = 8'h3e;
  localparam logic [7:0] CH_DELIM   = 8'h2f;
  localparam logic [7:0] CH_ASSIGN  = 8'h3d;
  localparam logic [7:0] CH_QUERY   = 8'h3f;
  localparam logic [7:0] CH_UNKNOWN = 8'h21;
  localparam logic [7:0] CH_MODE    = 8'h2a;
  localparam logic [7:0] CH_BUSY    = 8'h23;
  localparam logic [7:0] CH_ABSENT  = 8'h24;
  localparam logic [7:0] CH_CR      = 8'h0d;
  localparam logic [7:0] CH_LF      = 8'h0a;
  localparam logic [7:0] CH_ZERO    = 8'h30;
  localparam logic [7:0] CH_NINE    = 8'h39;
  localparam logic [7:0] CH_PERIOD  = 8'h2e;
  localparam logic [7:0] CH_COMMA   = 8'h2c;
  localparam logic [7:0] CH_UC_A    = 8'h41;
  localparam logic [7:0] CH_UC_Z    = 8'h5a;
  localparam logic [7:0] CH_LC_A    = 8'h61;
  localparam logic [7:0] CH_LC_Z    = 8'h7a;
  localparam int         ADDR_LEN   = 4;
  localparam int         CODE_LEN   = 3;
  localparam int         ARG_MAX    = 8;
  localparam int         CLK_HZ     = 10_000_000;
  localparam int         HW_GAP_MS  = 100;
  localparam int         HW_GAP_CYC = CLK_HZ / 1000 * HW_GAP_MS;

  // receive parser states, gray along the normal path from RPQ_IDLE up to RPQ_ARGS
  typedef enum logic [2:0] {
    RPQ_IDLE = 3'b000,
    RPQ_ADDR = 3'b001,
    RPQ_DLM  = 3'b011,
    RPQ_CODE = 3'b010,
    RPQ_QUAL = 3'b110,
    RPQ_ARGS = 3'b111,
    RPQ_SKIP = 3'b101
  } rpq_rx_state_t;

  function automatic logic rpq_is_alpha(input logic [7:0] c);
    return (c >= CH_UC_A && c <= CH_UC_Z) || (c >= CH_LC_A && c <= CH_LC_Z);
  endfunction

  function automatic logic rpq_is_arg(input logic [7:0] c);
    return (c >= CH_ZERO && c <= CH_NINE) || c == CH_PERIOD || c == CH_COMMA;
  endfunction
endpackage

// File: hw/rpq_pkt_if.sv
// interface carrying one completed, parsed packet from parser to responder
// assumes a single clock domain; done is a one-cycle pulse
interface rpq_pkt_if;
  logic                              done;     // packet terminated
  logic                              bad;      // framing or argument fault
  logic [rpq_pkg::ADDR_LEN*8-1:0]   addr;     // target address characters
  logic [rpq_pkg::CODE_LEN*8-1:0]   code;     // instruction code characters
  logic                              is_set;   // assignment qualifier seen
  logic [rpq_pkg::ARG_MAX*8-1:0]    args;     // arguments, first in low byte
  logic [3:0]                        arg_len;  // number of argument bytes
  logic                              busy;     // packet under evaluation or transmitter still replying

  modport parser (output done, bad, addr, code, is_set, args, arg_len, input busy);
  modport resp   (input done, bad, addr, code, is_set, args, arg_len, output busy);
endinterface

// File: hw/rpq_rx_parse.sv
// packet collector: frames controller packets from a received byte stream
// assumes rx_valid pulses once per byte from a uart on clk (8-N-1 done there)
module rpq_rx_parse (
  input  wire logic        clk,       // system clock
  input  wire logic        rst,       // async reset, high
  input  wire logic        rx_valid,  // received byte strobe
  input  wire logic [7:0]  rx_data,   // received byte
  rpq_pkt_if.parser        pkt        // parsed packet out
);
  rpq_pkg::rpq_rx_state_t st_r, st_nxt;
  logic [3:0] cnt_r;
  logic       bad_r;
  logic       last_addr;
  logic       last_code;

  assign last_addr = (cnt_r == 4'(rpq_pkg::ADDR_LEN - 1));
  assign last_code = (cnt_r == 4'(rpq_pkg::CODE_LEN - 1));

  always_comb
  begin
    st_nxt = st_r;
    if (rx_valid)
    begin
      if (rx_data == rpq_pkg::CH_SOP_RX)
        st_nxt = pkt.busy ? rpq_pkg::RPQ_IDLE : rpq_pkg::RPQ_ADDR;
      else
        case (st_r)
          rpq_pkg::RPQ_ADDR: if (last_addr) st_nxt = rpq_pkg::RPQ_DLM;
          rpq_pkg::RPQ_DLM:  st_nxt = rpq_pkg::RPQ_CODE;
          rpq_pkg::RPQ_CODE: if (last_code) st_nxt = rpq_pkg::RPQ_QUAL;
          rpq_pkg::RPQ_QUAL: st_nxt = rpq_pkg::RPQ_ARGS;
          rpq_pkg::RPQ_ARGS: if (rx_data == rpq_pkg::CH_CR) st_nxt = rpq_pkg::RPQ_IDLE;
          default:           st_nxt = rpq_pkg::RPQ_IDLE;
        endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_r        <= rpq_pkg::RPQ_IDLE;
      cnt_r       <= 4'h0;
      bad_r       <= 1'b0;
      pkt.done    <= 1'b0;
      pkt.bad     <= 1'b0;
      pkt.addr    <= '0;
      pkt.code    <= '0;
      pkt.is_set  <= 1'b0;
      pkt.args    <= '0;
      pkt.arg_len <= 4'h0;
    end
    else
    begin
      st_r     <= st_nxt;
      pkt.done <= 1'b0;
      if (rx_valid)
      begin
        if (rx_data == rpq_pkg::CH_SOP_RX)
        begin
          cnt_r       <= 4'h0;
          bad_r       <= 1'b0;
          pkt.arg_len <= 4'h0;
          pkt.args    <= '0;
        end
        else
          case (st_r)
            rpq_pkg::RPQ_ADDR:
            begin
              pkt.addr[cnt_r*8 +: 8] <= rx_data;
              cnt_r <= last_addr ? 4'h0 : cnt_r + 4'h1;
            end
            rpq_pkg::RPQ_DLM:
              if (rx_data != rpq_pkg::CH_DELIM) bad_r <= 1'b1;
            rpq_pkg::RPQ_CODE:
            begin
              if (!rpq_pkg::rpq_is_alpha(rx_data)) bad_r <= 1'b1;
              pkt.code[cnt_r*8 +: 8] <= rx_data;
              cnt_r <= last_code ? 4'h0 : cnt_r + 4'h1;
            end
            rpq_pkg::RPQ_QUAL:
            begin
              pkt.is_set <= (rx_data == rpq_pkg::CH_ASSIGN);
              if (rx_data != rpq_pkg::CH_ASSIGN && rx_data != rpq_pkg::CH_QUERY)
                bad_r <= 1'b1;
            end
            rpq_pkg::RPQ_ARGS:
              if (rx_data == rpq_pkg::CH_CR)
              begin
                pkt.done <= 1'b1;
                pkt.bad  <= bad_r;
              end
              else if (!rpq_pkg::rpq_is_arg(rx_data) ||
                       pkt.arg_len == 4'(rpq_pkg::ARG_MAX))
                bad_r <= 1'b1;
              else
              begin
                pkt.args[pkt.arg_len*8 +: 8] <= rx_data;
                pkt.arg_len <= pkt.arg_len + 4'h1;
              end
            default: ;
          endcase
      end
    end
  end

  sop_restart_a: assert property (@(posedge clk) disable iff (rst)
    rx_valid && rx_data == rpq_pkg::CH_SOP_RX && !pkt.busy |=> st_r == rpq_pkg::RPQ_ADDR)
    else $error("start char did not restart collection");
  no_done_early_a: assert property (@(posedge clk) disable iff (rst)
    pkt.done |-> $past(rx_valid) && $past(rx_data) == rpq_pkg::CH_CR)
    else $error("packet completed without terminator");
endmodule // rpq_rx_parse

// File: hw/rpq_tx_reply.sv
// reply transmitter: serialises one reply packet byte by byte
// assumes tx_ready from the uart; holds the link until the line feed goes out
module rpq_tx_reply (
  input  wire logic                            clk,      // system clock
  input  wire logic                            rst,      // async reset, high
  input  wire logic                            start,    // begin reply pulse
  input  wire logic [rpq_pkg::ADDR_LEN*8-1:0] addr,     // echoed address
  input  wire logic [rpq_pkg::CODE_LEN*8-1:0] code,     // echoed code
  input  wire logic [7:0]                      qual,     // reply qualifier
  input  wire logic                            val_en,   // append value byte
  input  wire logic [7:0]                      val,      // value character
  input  wire logic                            tx_ready, // uart can take byte
  output logic                                 tx_valid, // byte offered
  output logic [7:0]                           tx_data,  // byte
  output logic                                 busy      // reply in progress
);
  logic [3:0] idx_r;
  logic [7:0] byte_sel;
  logic       last;
  logic [3:0] idx_last;

  // reply layout: > a a a a / c c c q [v] cr lf
  assign idx_last = val_en ? 4'd12 : 4'd11;
  assign last     = (idx_r == idx_last);

  always_comb
  begin
    byte_sel = rpq_pkg::CH_LF;
    if (idx_r == 4'd0)
      byte_sel = rpq_pkg::CH_SOP_TX;
    else if (idx_r <= 4'd4)
      byte_sel = addr[(idx_r - 4'd1)*8 +: 8];
    else if (idx_r == 4'd5)
      byte_sel = rpq_pkg::CH_DELIM;
    else if (idx_r <= 4'd8)
      byte_sel = code[(idx_r - 4'd6)*8 +: 8];
    else if (idx_r == 4'd9)
      byte_sel = qual;
    else if (val_en && idx_r == 4'd10)
      byte_sel = val;
    else if (idx_r == idx_last - 4'd1)
      byte_sel = rpq_pkg::CH_CR;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy     <= 1'b0;
      idx_r    <= 4'h0;
      tx_valid <= 1'b0;
      tx_data  <= 8'h00;
    end
    else if (!busy)
    begin
      if (start)
      begin
        busy  <= 1'b1;
        idx_r <= 4'h0;
      end
    end
    else if (!tx_valid)
    begin
      tx_valid <= 1'b1;
      tx_data  <= byte_sel;
    end
    else if (tx_ready)
    begin
      tx_valid <= 1'b0;
      idx_r    <= idx_r + 4'h1;
      if (last)
        busy <= 1'b0;
    end
  end

  lf_after_cr_a: assert property (@(posedge clk) disable iff (rst)
    tx_valid && tx_ready && tx_data == rpq_pkg::CH_CR |=> ##1 tx_data == rpq_pkg::CH_LF)
    else $error("carriage return not followed by line feed");
endmodule // rpq_tx_reply

// File: hw/rpq_handler.sv
// remote packet qualifier handler: top level
// assumes uart bytes on clk, parameter store and mode/fit status from the unit
//
// Contract
// - assignment qualifier writes the arguments into the selected parameter
// - query qualifier returns the selected parameter's present value
// - query reply is code, =, value; 1 enabled, 0 disabled
// - accepted set is echoed as code and = with no arguments
// - invalid set argument answers code and ?, parameter untouched
// - unknown instruction code is echoed followed by !
// - set forbidden by current mode answers code and *
// - hardware configuration set while hardware busy answers code and #
// - absent converter module answers with $ qualifier
// - arguments optional; only digits, period and comma are valid
// - every reply ends with carriage return then line feed
// - nothing is acted on before the packet terminator arrives
// - packets start with < inbound and > outbound, nowhere else
// - instruction code is exactly three letters of either case
// - reply carries the same four-character address as the request
// - characters are 8-N-1 asynchronous, framed by the uart
module rpq_handler #(
  parameter int HW_GAP = rpq_pkg::HW_GAP_CYC  // hardware settle cycles
) (
  input  wire logic        clk,         // 10 MHz system clock
  input  wire logic        rst,         // async reset, high
  input  wire logic        rx_valid,    // byte from uart receiver
  input  wire logic [7:0]  rx_data,     // received byte
  input  wire logic        tx_ready,    // uart transmitter ready
  input  wire logic        code_known,  // code lookup hit, from command table
  input  wire logic        code_hw,     // code is hardware configuration
  input  wire logic        code_valid_arg, // arguments legal for code
  input  wire logic        mode_lock,   // mode forbids change, e.g. standby
  input  wire logic        module_fit,  // addressed converter fitted
  input  wire logic        addr_match,  // address is ours
  input  wire logic [7:0]  param_val,   // present value character of code
  output logic             tx_valid,    // byte offered to uart
  output logic [7:0]       tx_data,     // byte to send
  output logic             lookup_req,  // hold code for lookup, level
  output logic [23:0]      lookup_code, // instruction code for lookup
  output logic             param_wr,    // write parameter pulse
  output logic [63:0]      param_args,  // argument bytes to store
  output logic [3:0]       param_len    // argument count
);
  // the busy window check watches eight cycles, so gaps under nine cycles are refused
  if (HW_GAP < 9)
  begin : g_gap_chk
    $error("hw gap must be at least nine cycles");
  end

  rpq_pkt_if pkt ();

  // all checks below run on clk and sleep through reset
  default clocking chk_cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic       sync1_r;
  logic       sync2_r;
  logic [7:0] d1_r;
  logic [7:0] d2_r;
  logic       v1_r;
  logic       v2_r;
  logic       eval_r;
  logic       start_r;
  logic [7:0] qual_r;
  logic       val_en_r;
  logic [31:0] gap_r;
  logic       hw_busy;
  logic       bad_arg;
  logic [7:0] qual_sel;
  logic       tx_busy;
  logic       tx_valid_w;
  logic [7:0] tx_data_w;

  // bytes arrive already framed 8-N-1 by the uart
  // rx byte stream comes from the uart on clk, but its strobe is registered
  // twice here so the lookup table has a cycle to settle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      v1_r <= 1'b0;
      v2_r <= 1'b0;
      d1_r <= 8'h00;
      d2_r <= 8'h00;
    end
    else
    begin
      v1_r <= rx_valid;
      v2_r <= v1_r;
      d1_r <= rx_data;
      d2_r <= d1_r;
    end
  end

  rpq_rx_parse u_parse (
    .clk      (clk),
    .rst      (rst),
    .rx_valid (v2_r),
    .rx_data  (d2_r),
    .pkt      (pkt)
  );

  assign pkt.busy = tx_busy || eval_r || start_r;
  assign hw_busy  = (gap_r != 32'h0);
  assign bad_arg  = pkt.bad || (pkt.is_set && !code_valid_arg);

  assign qual_sel = !module_fit                ? rpq_pkg::CH_ABSENT  :
                    !code_known                ? rpq_pkg::CH_UNKNOWN :
                    bad_arg                    ? rpq_pkg::CH_QUERY   :
                    pkt.is_set && mode_lock    ? rpq_pkg::CH_MODE    :
                    pkt.is_set && code_hw && hw_busy ? rpq_pkg::CH_BUSY :
                    rpq_pkg::CH_ASSIGN;

  // a packet arriving while a reply is pending is dropped by the parser, so
  // the address and code echoed below stay put until the line feed is out
  // evaluation runs one cycle after the packet completes so the lookup has
  // the stable code; replies only to our address
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      eval_r      <= 1'b0;
      start_r     <= 1'b0;
      qual_r      <= rpq_pkg::CH_ASSIGN;
      val_en_r    <= 1'b0;
      param_wr    <= 1'b0;
      gap_r       <= 32'h0;
      lookup_req  <= 1'b0;
      lookup_code <= 24'h0;
      param_args  <= 64'h0;
      param_len   <= 4'h0;
    end
    else
    begin
      start_r  <= 1'b0;
      param_wr <= 1'b0;
      eval_r   <= pkt.done;
      if (hw_busy)
        gap_r <= gap_r - 32'h1;
      if (pkt.done)
      begin
        lookup_req  <= 1'b1;
        lookup_code <= pkt.code;
        param_args  <= pkt.args;
        param_len   <= pkt.arg_len;
      end
      if (eval_r)
      begin
        lookup_req <= 1'b0;
        if (addr_match)
        begin
          start_r  <= 1'b1;
          qual_r   <= qual_sel;
          // query answered with value, code = value
          val_en_r <= !pkt.is_set && qual_sel == rpq_pkg::CH_ASSIGN;
          if (pkt.is_set && qual_sel == rpq_pkg::CH_ASSIGN)
          begin
            param_wr <= 1'b1;
            if (code_hw)
              gap_r <= 32'(HW_GAP);
          end
        end
      end
    end
  end

  rpq_tx_reply u_tx (
    .clk      (clk),
    .rst      (rst),
    .start    (start_r),
    .addr     (pkt.addr),
    .code     (pkt.code),
    .qual     (qual_r),
    .val_en   (val_en_r),
    .val      (param_val),
    .tx_ready (tx_ready),
    .tx_valid (tx_valid_w),
    .tx_data  (tx_data_w),
    .busy     (tx_busy)
  );

  assign tx_valid = tx_valid_w;
  assign tx_data  = tx_data_w;

  no_write_bad_a: assert property (
    param_wr |-> $past(qual_sel) == rpq_pkg::CH_ASSIGN && $past(pkt.is_set))
    else $error("parameter written without accepted set");

  wr_pulse_a: assert property (
    param_wr |=> !param_wr)
    else $error("parameter write longer than one cycle");

  set_args_a: assert property (
    param_wr |-> param_args == $past(pkt.args, 2) && param_len == $past(pkt.arg_len, 2))
    else $error("written arguments differ from packet");

  busy_reject_a: assert property (
    param_wr && $past(code_hw) |=> hw_busy [*8])
    else $error("hardware gap not held after set");

  busy_open_a: assert property (
    !hw_busy |=> !hw_busy || param_wr)
    else $error("hardware gap opened without a write");

  busy_reply_a: assert property (
    eval_r && addr_match && module_fit && code_known && !bad_arg && pkt.is_set &&
      !mode_lock && code_hw && hw_busy |=> qual_r == rpq_pkg::CH_BUSY && !param_wr)
    else $error("busy hardware set not refused");

  start_reply_a: assert property (
    eval_r && addr_match |=> start_r)
    else $error("reply not started after packet");

  start_once_a: assert property (
    start_r |=> !start_r)
    else $error("reply started twice");

  silent_other_a: assert property (
    eval_r && !addr_match |=> !start_r && !param_wr)
    else $error("reply or write for another address");

  query_value_a: assert property (
    start_r && val_en_r |-> qual_r == rpq_pkg::CH_ASSIGN)
    else $error("value sent with non accept qualifier");

  query_answer_a: assert property (
    eval_r && addr_match && module_fit && code_known && !pkt.bad && !pkt.is_set
      |=> val_en_r && qual_r == rpq_pkg::CH_ASSIGN && !param_wr)
    else $error("query not answered with value");

  set_echo_a: assert property (
    eval_r && addr_match && pkt.is_set |=> !val_en_r)
    else $error("set reply carries a value");

  absent_first_a: assert property (
    eval_r && addr_match && !module_fit |=> qual_r == rpq_pkg::CH_ABSENT && !param_wr)
    else $error("absent module not reported first");

  unknown_code_a: assert property (
    eval_r && addr_match && module_fit && !code_known |=>
      qual_r == rpq_pkg::CH_UNKNOWN && !param_wr)
    else $error("unknown code not reported");

  bad_arg_a: assert property (
    eval_r && addr_match && module_fit && code_known && pkt.bad |=>
      qual_r == rpq_pkg::CH_QUERY && !param_wr)
    else $error("bad packet not answered with query mark");

  mode_lock_a: assert property (
    eval_r && addr_match && module_fit && code_known && !bad_arg &&
      pkt.is_set && mode_lock |=> qual_r == rpq_pkg::CH_MODE && !param_wr)
    else $error("mode lock not honoured");

  reply_sop_a: assert property (
    start_r |-> ##[1:3] tx_valid && tx_data == rpq_pkg::CH_SOP_TX)
    else $error("reply did not open with start char");

  lookup_done_a: assert property (
    $rose(lookup_req) |-> $past(pkt.done))
    else $error("lookup raised before packet end");

  tx_hold_a: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply byte dropped before the uart took it");

  set_cov: cover property (param_wr);
  query_cov: cover property (start_r && val_en_r);
  busy_cov: cover property (start_r && qual_r == rpq_pkg::CH_BUSY);
  reject_cov: cover property (start_r && qual_r == rpq_pkg::CH_QUERY);
  silent_cov: cover property (eval_r && !addr_match);
endmodule // rpq_handler

// File: testbench/rpq_ctrl_model.sv
// controller model: sends packets byte by byte and collects reply bytes
// assumes a uart outside the block has done the character framing
module rpq_ctrl_model (
  input  wire logic       clk,      // system clock
  output logic            rx_valid, // byte strobe to the handler
  output logic [7:0]      rx_data,  // byte to the handler
  output logic            tx_ready, // reply byte taken
  input  wire logic       tx_valid, // reply byte offered
  input  wire logic [7:0] tx_data   // reply byte
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] got[$];
  bit         slow = 1'b0;
  logic       tick = 1'b0;

  initial
  begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
  end

  // slow mode stalls every other cycle so held bytes get exercised
  always @(posedge clk)
  begin
    tick     <= ~tick;
    tx_ready <= ~slow | tick;
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      got.push_back(tx_data);
  end

  // one byte per strobe, caller frames the packet
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++)
    begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data  <= s[i];
      @(posedge clk);
      rx_valid <= 1'b0;
      // released line shows no stale byte
      rx_data  <= ~s[i];
    end
  endtask
endmodule // rpq_ctrl_model

// File: testbench/rpq_handler_bench.sv
// self-checking bench for the remote packet qualifier handler
// assumes the controller model drives bytes and the bench plays the command table
module rpq_handler_bench;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int    GAP  = 200;
  localparam string CR   = "\015";
  localparam string CRLF = "\015\012";

  logic        clk            = 1'b0;
  logic        rst            = 1'b1;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        tx_ready;
  logic        tx_valid;
  logic [7:0]  tx_data;
  logic        code_known     = 1'b1;
  logic        code_hw        = 1'b0;
  logic        code_valid_arg = 1'b1;
  logic        mode_lock      = 1'b0;
  logic        module_fit     = 1'b1;
  logic        addr_match     = 1'b1;
  logic [7:0]  param_val      = 8'h31;
  logic        lookup_req;
  logic [23:0] lookup_code;
  logic        param_wr;
  logic [63:0] param_args;
  logic [3:0]  param_len;
  logic [63:0] wr_args        = 64'h0;
  logic [3:0]  wr_len         = 4'h0;
  int          wr_cnt         = 0;
  int          lk_cnt         = 0;
  int          fails          = 0;
  int          n_checks       = 0;

  always #50 clk = ~clk;

  rpq_ctrl_model ctrl (
    .clk      (clk),
    .rx_valid (rx_valid),
    .rx_data  (rx_data),
    .tx_ready (tx_ready),
    .tx_valid (tx_valid),
    .tx_data  (tx_data)
  );

  rpq_handler #(.HW_GAP(GAP)) DUT (
    .clk            (clk),
    .rst            (rst),
    .rx_valid       (rx_valid),
    .rx_data        (rx_data),
    .tx_ready       (tx_ready),
    .code_known     (code_known),
    .code_hw        (code_hw),
    .code_valid_arg (code_valid_arg),
    .mode_lock      (mode_lock),
    .module_fit     (module_fit),
    .addr_match     (addr_match),
    .param_val      (param_val),
    .tx_valid       (tx_valid),
    .tx_data        (tx_data),
    .lookup_req     (lookup_req),
    .lookup_code    (lookup_code),
    .param_wr       (param_wr),
    .param_args     (param_args),
    .param_len      (param_len)
  );

  // a stretched write pulse shows up as an extra count
  always @(posedge clk)
    if (param_wr === 1'b1)
    begin
      wr_cnt  <= wr_cnt + 1;
      wr_args <= param_args;
      wr_len  <= param_len;
    end

  // one lookup cycle is expected per terminated packet
  always @(posedge clk)
    if (lookup_req === 1'b1)
      lk_cnt <= lk_cnt + 1;

  task automatic conclude();
    if (fails == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic check_reply(input string exp);
    check_val(64'(ctrl.got.size()), 64'(exp.len()));
    for (int i = 0; i < exp.len() && i < ctrl.got.size(); i++)
      check_val(64'(ctrl.got[i]), 64'(exp[i]));
  endtask

  // order: fit, known, valid argument, mode lock, hardware, address match
  task automatic flags(input logic [5:0] f);
    @(posedge clk);
    {module_fit, code_known, code_valid_arg, mode_lock, code_hw, addr_match} <= f;
  endtask

  task automatic run(input string pkt, input string exp, input int nwr);
    int k;
    ctrl.got.delete();
    wr_cnt = 0;
    lk_cnt = 0;
    ctrl.send(pkt);
    k = 0;
    while (k < 400 && (exp.len() == 0 || ctrl.got.size() < exp.len()))
    begin
      @(posedge clk);
      k++;
    end
    // an unfinished reply is a mismatch and ends the simulation
    if (ctrl.got.size() < exp.len())
    begin
      check_val(64'(ctrl.got.size()), 64'(exp.len()));
      conclude();
    end
    else
    begin
      repeat (6) @(posedge clk);
      check_reply(exp);
      check_val(64'(wr_cnt), 64'(nwr));
      check_val(64'(lk_cnt), 64'h1);
    end
  endtask

  task automatic t_query();
    flags(6'b111001);
    run({"<0412/MUT?", CR}, {">0412/MUT=1", CRLF}, 0);
    check_val(64'(lookup_code), 64'h54554d);
    param_val <= 8'h30;
    ctrl.slow = 1'b1;
    run({"<9876/MUT?", CR}, {">9876/MUT=0", CRLF}, 0);
    ctrl.slow = 1'b0;
  endtask

  task automatic t_set();
    run({"<0412/mut=1.5,0", CR}, {">0412/mut=", CRLF}, 1);
    check_val(64'(wr_len), 64'h5);
    check_val(wr_args, 64'h302c352e31);
  endtask

  task automatic t_reject();
    flags(6'b110101);
    run({"<0412/FRE=7", CR}, {">0412/FRE?", CRLF}, 0);
    flags(6'b111001);
    run({"<0412/FRE=7A", CR}, {">0412/FRE?", CRLF}, 0);
    run({"<0412/FRE!7", CR}, {">0412/FRE?", CRLF}, 0);
    flags(6'b111101);
    run({"<0412/FRE=7", CR}, {">0412/FRE*", CRLF}, 0);
    flags(6'b100101);
    run({"<0412/XYZ=7", CR}, {">0412/XYZ!", CRLF}, 0);
    flags(6'b000001);
    run({"<0412/XYZ=7", CR}, {">0412/XYZ$", CRLF}, 0);
    flags(6'b111000);
    run({"<0413/FRE=7", CR}, "", 0);
  endtask

  task automatic t_busy();
    flags(6'b111011);
    run({"<0412/ATT=5", CR}, {">0412/ATT=", CRLF}, 1);
    run({"<0412/ATT=6", CR}, {">0412/ATT#", CRLF}, 0);
    flags(6'b111111);
    run({"<0412/ATT=6", CR}, {">0412/ATT*", CRLF}, 0);
    flags(6'b111011);
    repeat (GAP) @(posedge clk);
    run({"<0412/ATT=6", CR}, {">0412/ATT=", CRLF}, 1);
    check_val(wr_args, 64'h36);
  endtask

  task automatic t_frame();
    flags(6'b111001);
    ctrl.got.delete();
    wr_cnt = 0;
    lk_cnt = 0;
    ctrl.send("<0412/MUT=9");
    repeat (40) @(posedge clk);
    check_val(64'(ctrl.got.size()), 64'h0);
    check_val(64'(wr_cnt), 64'h0);
    check_val(64'(lk_cnt), 64'h0);
    run({"<0412/MUT=1", CR}, {">0412/MUT=", CRLF}, 1);
    check_val(wr_args, 64'h31);
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_query();
    t_set();
    t_reject();
    t_busy();
    t_frame();
    conclude();
  end
endmodule // rpq_handler_bench
